// ### hdl/fe_cfg_params.svh
// Constants for the converter front-end configuration register slice.
// Assumes inclusion by the package and the top module by bare name.
// Contract
// RULE1 - Location 0x0F is read-only, always reads zero, resets to zero.
// RULE2 - Amplifier register bit 7: 0 keeps amplifier active, 1 bypasses it.
// RULE3 - Amplifier register at 0x10 resets zero; gain code n gives gain 2^n.
// RULE4 - Positive selector bits 7:4 decode common, inputs 0-9, sensors, open, mid-supply.
// RULE5 - Negative selector bits 3:0 use the same code mapping.
// RULE6 - Input select register at 0x11 resets to 0xFF, both mid-supply.
// RULE7 - Bias register bit 4 connects level-shift bias to common input pin.
// RULE8 - Bias register bit 3: 0 pull-up, 1 pull-down burn-out current.
// RULE9 - Bias bits 2:0: off, 50nA, 200nA, 1uA, 10uA; 101-111 reserved.
// RULE10 - Bias register at 0x12 resets to 0x00.
// RULE11 - Host writes zero to reserved bits and avoids reserved magnitude codes.
// RULE12 - Writes to location 0x0F are ignored; it keeps reading zero.
`ifndef FE_CFG_PARAMS_SVH
`define FE_CFG_PARAMS_SVH

// --------------------------------------------------------------------------
// Register indices and byte addresses (index times four)
// --------------------------------------------------------------------------
`define ZERO_FILLER_IDX 8'h0F
`define AMP_CFG_IDX 8'h10
`define SRC_SEL_IDX 8'h11
`define BIAS_CFG_IDX 8'h12
`define ADDR_W 8
`define ZERO_FILLER_ADDR 8'h3C
`define AMP_CFG_ADDR 8'h40
`define SRC_SEL_ADDR 8'h44
`define BIAS_CFG_ADDR 8'h48

// --------------------------------------------------------------------------
// Reset values and field positions
// --------------------------------------------------------------------------
`define ZERO_FILLER_RST 8'h00
`define AMP_CFG_RST 8'h00
`define SRC_SEL_RST 8'hFF
`define BIAS_CFG_RST 8'h00
`define AMP_BYPASS_BIT 7
`define AMP_GAIN_LSB 0
`define SRC_POS_LSB 4
`define SRC_NEG_LSB 0
`define BIAS_LSV_BIT 4
`define BIAS_POL_BIT 3
`define BIAS_MAG_LSB 0
`define BURNOUT_MAX_CODE 3'h4
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ### hdl/fe_cfg_pkg.sv
// Types for the converter front-end configuration register slice.
// Assumes the params header sits on the include path.
`default_nettype none
package fe_cfg_pkg;
`include "fe_cfg_params.svh"

  typedef enum logic [3:0] {
    SRC_COMMON = 4'h0, SRC_ANALOG_INPUT_ZERO = 4'h1, SRC_AIN1 = 4'h2, SRC_AIN2 = 4'h3,
    SRC_AIN3 = 4'h4, SRC_AIN4 = 4'h5, SRC_AIN5 = 4'h6, SRC_AIN6 = 4'h7,
    SRC_AIN7 = 4'h8, SRC_AIN8 = 4'h9, SRC_ANALOG_INPUT_NINE = 4'hA, SRC_TEMP = 4'hB,
    SRC_AVDD_DIV4 = 4'hC, SRC_DVDD_DIV4 = 4'hD, SRC_OPEN = 4'hE, SRC_MID_SUPPLY = 4'hF
  } input_source_t;

  typedef struct packed {
    logic bypass;          // Amplifier bypassed
    logic [7:0] gain;      // One-hot gain, bit n = gain 2^n
    logic [15:0] pos_sel;  // One-hot positive source
    logic [15:0] neg_sel;  // One-hot negative source
    logic bias_enable;     // Level-shift bias on common pin
    logic pull_down;       // Burn-out current direction
    logic [4:0] burnout;   // One-hot magnitude: off,50n,200n,1u,10u
    logic burnout_bad;     // Reserved magnitude code programmed
  } analog_ctrl_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_WRESP = 2'b01,
    BUS_RRESP = 2'b10
  } bus_state_t;

  typedef struct packed {
    logic [7:0] amp_cfg_reg;
    logic [7:0] src_sel_reg;
    logic [7:0] bias_cfg_reg;
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic arready;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    analog_ctrl_t ctrl;
  } regs_state_t;

endpackage : fe_cfg_pkg
`default_nettype wire

// ### hdl/fe_cfg_decode.sv
// Decodes the three stored configuration bytes into one-hot analog controls.
// Purely combinational; the top registers its result.
`default_nettype none
`include "fe_cfg_params.svh"
module fe_cfg_decode
  import fe_cfg_pkg::*;
(
  input wire logic [7:0] amp_cfg,     // Amplifier configuration byte
  input wire logic [7:0] src_sel,     // Input source select byte
  input wire logic [7:0] bias_cfg,    // Input bias configuration byte
  output analog_ctrl_t ctrl           // Decoded controls
);

  function automatic logic [15:0] src_onehot(input logic [3:0] code);
    src_onehot = 16'h0001 << code;
  endfunction : src_onehot

  always_comb
  begin
    ctrl = '0;
    ctrl.bypass = amp_cfg[`AMP_BYPASS_BIT];                                // [RULE2]
    ctrl.gain = 8'h01 << amp_cfg[`AMP_GAIN_LSB +: 3];                      // [RULE3]
    ctrl.pos_sel = src_onehot(src_sel[`SRC_POS_LSB +: 4]);                 // [RULE4]
    ctrl.neg_sel = src_onehot(src_sel[`SRC_NEG_LSB +: 4]);                 // [RULE5]
    ctrl.bias_enable = bias_cfg[`BIAS_LSV_BIT];                            // [RULE7]
    ctrl.pull_down = bias_cfg[`BIAS_POL_BIT];                              // [RULE8]
    // Reserved magnitude codes leave the sources off rather than guess
    if (bias_cfg[`BIAS_MAG_LSB +: 3] > `BURNOUT_MAX_CODE)
    begin
      ctrl.burnout = 5'h01;                                                // [RULE9]
      ctrl.burnout_bad = 1'b1;
    end
    else
    begin
      ctrl.burnout = 5'h01 << bias_cfg[`BIAS_MAG_LSB +: 3];                // [RULE9]
    end
  end

endmodule : fe_cfg_decode
`default_nettype wire

// ### hdl/fe_cfg_regs.sv
// AXI4-Lite slave holding the converter front-end configuration registers.
// Assumes a single 100 MHz clock and same-domain AXI master.
`default_nettype none
`include "fe_cfg_params.svh"
module fe_cfg_regs
  import fe_cfg_pkg::*;
(
  input wire logic CLOCK,                 // 100 MHz clock
  input wire logic ARST_N,                // Async reset, active low
  input wire logic [7:0] S_AXI_AWADDR,    // Write address
  input wire logic S_AXI_AWVALID,         // Write address valid
  output logic S_AXI_AWREADY,             // Write address ready
  input wire logic [31:0] S_AXI_WDATA,    // Write data
  input wire logic [3:0] S_AXI_WSTRB,     // Write strobes
  input wire logic S_AXI_WVALID,          // Write data valid
  output logic S_AXI_WREADY,              // Write data ready
  output logic [1:0] S_AXI_BRESP,         // Write response
  output logic S_AXI_BVALID,              // Write response valid
  input wire logic S_AXI_BREADY,          // Write response ready
  input wire logic [7:0] S_AXI_ARADDR,    // Read address
  input wire logic S_AXI_ARVALID,         // Read address valid
  output logic S_AXI_ARREADY,             // Read address ready
  output logic [31:0] S_AXI_RDATA,        // Read data
  output logic [1:0] S_AXI_RRESP,         // Read response
  output logic S_AXI_RVALID,              // Read data valid
  input wire logic S_AXI_RREADY,          // Read data ready
  output analog_ctrl_t ANALOG_CTRL        // Registered analog controls
);

  regs_state_t st_reg;
  regs_state_t st_next;
  analog_ctrl_t ctrl_dec;

  // --------------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------------
  function automatic logic addr_known(input logic [7:0] a);
    addr_known = (a == `ZERO_FILLER_ADDR) || (a == `AMP_CFG_ADDR) ||
                 (a == `SRC_SEL_ADDR) || (a == `BIAS_CFG_ADDR);
  endfunction : addr_known

  function automatic logic [7:0] read_byte(input regs_state_t s, input logic [7:0] a);
    case (a)
      `ZERO_FILLER_ADDR: read_byte = `ZERO_FILLER_RST;  // [RULE1]
      `AMP_CFG_ADDR: read_byte = s.amp_cfg_reg;
      `SRC_SEL_ADDR: read_byte = s.src_sel_reg;
      `BIAS_CFG_ADDR: read_byte = s.bias_cfg_reg;
      default: read_byte = 8'h00;
    endcase
  endfunction : read_byte

  fe_cfg_decode u_decode (
    .amp_cfg(st_reg.amp_cfg_reg),
    .src_sel(st_reg.src_sel_reg),
    .bias_cfg(st_reg.bias_cfg_reg),
    .ctrl(ctrl_dec)
  );

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb
  begin
    st_next = st_reg;
    st_next.ctrl = ctrl_dec;

    // Write address and data are caught in either order
    if (st_reg.awready && S_AXI_AWVALID)
    begin
      st_next.aw_got = 1'b1;
      st_next.aw_addr = S_AXI_AWADDR;
      st_next.awready = 1'b0;
    end
    if (st_reg.wready && S_AXI_WVALID)
    begin
      st_next.w_got = 1'b1;
      st_next.w_data = S_AXI_WDATA;
      st_next.w_strb = S_AXI_WSTRB;
      st_next.wready = 1'b0;
    end

    // Commit once both halves are held and no response is pending
    if (st_reg.aw_got && st_reg.w_got && !st_reg.bvalid)
    begin
      st_next.aw_got = 1'b0;
      st_next.w_got = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = addr_known(st_reg.aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
      if (st_reg.w_strb[0])
      begin
        case (st_reg.aw_addr)
          `AMP_CFG_ADDR: st_next.amp_cfg_reg = st_reg.w_data[7:0];     // [RULE2] [RULE3]
          `SRC_SEL_ADDR: st_next.src_sel_reg = st_reg.w_data[7:0];     // [RULE4] [RULE5]
          `BIAS_CFG_ADDR: st_next.bias_cfg_reg = st_reg.w_data[7:0];   // [RULE7] [RULE8] [RULE9]
          // Zero filler slot takes no store: writes are dropped
          `ZERO_FILLER_ADDR: st_next.bresp = `RESP_OKAY;              // [RULE12]
          default: st_next.bresp = `RESP_SLVERR;
        endcase
      end
    end

    if (st_reg.bvalid && S_AXI_BREADY)
    begin
      st_next.bvalid = 1'b0;
      st_next.awready = 1'b1;
      st_next.wready = 1'b1;
    end

    // Read: one outstanding; arready drops until the data is taken
    if (st_reg.arready && S_AXI_ARVALID)
    begin
      st_next.arready = 1'b0;
      st_next.rvalid = 1'b1;
      st_next.rdata = {24'h00_0000, read_byte(st_reg, S_AXI_ARADDR)};
      st_next.rresp = addr_known(S_AXI_ARADDR) ? `RESP_OKAY : `RESP_SLVERR;
    end
    if (st_reg.rvalid && S_AXI_RREADY)
    begin
      st_next.rvalid = 1'b0;
      st_next.arready = 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      st_reg <= '0;
      st_reg.amp_cfg_reg <= `AMP_CFG_RST;       // [RULE3]
      st_reg.src_sel_reg <= `SRC_SEL_RST;       // [RULE6]
      st_reg.bias_cfg_reg <= `BIAS_CFG_RST;     // [RULE10]
      st_reg.awready <= 1'b1;
      st_reg.wready <= 1'b1;
      st_reg.arready <= 1'b1;
      st_reg.ctrl.gain <= 8'h01;
      st_reg.ctrl.pos_sel <= 16'h8000;          // [RULE6]
      st_reg.ctrl.neg_sel <= 16'h8000;
      st_reg.ctrl.burnout <= 5'h01;             // [RULE10]
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign S_AXI_AWREADY = st_reg.awready;
  assign S_AXI_WREADY = st_reg.wready;
  assign S_AXI_BVALID = st_reg.bvalid;
  assign S_AXI_BRESP = st_reg.bresp;
  assign S_AXI_ARREADY = st_reg.arready;
  assign S_AXI_RVALID = st_reg.rvalid;
  assign S_AXI_RDATA = st_reg.rdata;
  assign S_AXI_RRESP = st_reg.rresp;
  assign ANALOG_CTRL = st_reg.ctrl;

endmodule : fe_cfg_regs
`default_nettype wire

// ### dv/fe_cfg_regs_sva.sv
// Checker for the front-end register slice, on top-level ports only.
// Assumes one clock domain and reset released off the sampling edge.
`default_nettype none
module fe_cfg_regs_sva
  import fe_cfg_pkg::*;
(
  input wire logic CLOCK, // Clock
  input wire logic ARST_N, // Reset
  input wire logic [7:0] S_AXI_AWADDR, // Addr
  input wire logic S_AXI_AWVALID, // Valid
  input wire logic S_AXI_AWREADY, // Ready
  input wire logic S_AXI_WVALID, // Valid
  input wire logic S_AXI_WREADY, // Ready
  input wire logic [1:0] S_AXI_BRESP, // Resp
  input wire logic S_AXI_BVALID, // Valid
  input wire logic [7:0] S_AXI_ARADDR, // Addr
  input wire logic S_AXI_ARVALID, // Valid
  input wire logic S_AXI_ARREADY, // Ready
  input wire logic [31:0] S_AXI_RDATA, // Data
  input wire logic S_AXI_RVALID, // Valid
  input wire analog_ctrl_t ANALOG_CTRL // Controls
);
  timeunit 1ns;
  timeprecision 1ps;
  // Read data and controls both reflect the register before the read edge
  logic [7:0] rd_addr_reg;
  logic [2:0] mag;
  logic wr_take;
  assign mag = S_AXI_RDATA[2:0];
  assign wr_take = S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  always_ff @(posedge CLOCK or negedge ARST_N)
    if (!ARST_N)
      rd_addr_reg <= 8'h00;
    else if (S_AXI_ARVALID && S_AXI_ARREADY)
      rd_addr_reg <= S_AXI_ARADDR;
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!ARST_N);
  property p_zero_read;
    $rose(S_AXI_RVALID) && rd_addr_reg == 8'h3C |-> S_AXI_RDATA == 32'h0000_0000;
  endproperty
  a_zero_read: assert property (p_zero_read) else $error("zero slot read nonzero");
  property p_amp;
    $rose(S_AXI_RVALID) && rd_addr_reg == 8'h40 |-> ANALOG_CTRL.gain == (8'h01 << mag)
      && ANALOG_CTRL.bypass == S_AXI_RDATA[7];
  endproperty
  a_amp: assert property (p_amp) else $error("amplifier decode wrong");
  property p_src;
    $rose(S_AXI_RVALID) && rd_addr_reg == 8'h44 |-> ANALOG_CTRL.pos_sel == (16'h0001 << S_AXI_RDATA[7:4])
      && ANALOG_CTRL.neg_sel == (16'h0001 << S_AXI_RDATA[3:0]);
  endproperty
  a_src: assert property (p_src) else $error("source decode wrong");
  property p_bias;
    $rose(S_AXI_RVALID) && rd_addr_reg == 8'h48 |-> ANALOG_CTRL.bias_enable == S_AXI_RDATA[4]
      && ANALOG_CTRL.pull_down == S_AXI_RDATA[3];
  endproperty
  a_bias: assert property (p_bias) else $error("bias decode wrong");
  property p_burnout;
    $rose(S_AXI_RVALID) && rd_addr_reg == 8'h48 |-> ANALOG_CTRL.burnout == (mag > 3'h4 ? 5'h01 : 5'h01 << mag);
  endproperty
  a_burnout: assert property (p_burnout) else $error("burnout decode wrong");
  property p_reset_ctrl;
    $rose(ARST_N) |-> ANALOG_CTRL.gain == 8'h01 && ANALOG_CTRL.pos_sel == 16'h8000
      && ANALOG_CTRL.neg_sel == 16'h8000 && ANALOG_CTRL.burnout == 5'h01 && !ANALOG_CTRL.bias_enable;
  endproperty
  a_reset_ctrl: assert property (p_reset_ctrl) else $error("controls not at reset");
  property p_zero_write;
    wr_take && S_AXI_AWADDR == 8'h3C |-> ##2 S_AXI_BVALID && S_AXI_BRESP == 2'h0;
  endproperty
  a_zero_write: assert property (p_zero_write) else $error("zero slot write response wrong");
  property p_zero_quiet;
    wr_take && S_AXI_AWADDR == 8'h3C |-> ##1 $stable(ANALOG_CTRL) [*3];
  endproperty
  a_zero_quiet: assert property (p_zero_quiet) else $error("zero slot write moved controls");
endmodule : fe_cfg_regs_sva
bind fe_cfg_regs fe_cfg_regs_sva chk (.CLOCK, .ARST_N, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY,
  .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_ARADDR, .S_AXI_ARVALID,
  .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RVALID, .ANALOG_CTRL);
`default_nettype wire

// ### dv/testbench.sv
// Self-checking bench for the front-end register slice over AXI4-Lite.
// Assumes the hand-over timing; the bench is the bus master itself.
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin err_count++; $display("mismatch %s exp %h got %h", n, e, g); end end
module testbench
  import fe_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLOCK, ARST_N, S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID, S_AXI_BREADY;
  logic S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY;
  logic [7:0] S_AXI_AWADDR, S_AXI_ARADDR;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA;
  logic [3:0] S_AXI_WSTRB;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP, rs;
  analog_ctrl_t ANALOG_CTRL;
  int err_count, cmp_count, cyc;
  // Row: address, written byte, byte read back, response
  typedef struct packed {logic [7:0] a; logic [7:0] w; logic [7:0] r; logic [1:0] s;} row_t;
  row_t rows [5] = '{'{8'h3C, 8'hFF, 8'h00, 2'h0}, '{8'h40, 8'h83, 8'h83, 2'h0},
    '{8'h44, 8'h3A, 8'h3A, 2'h0}, '{8'h48, 8'h1C, 8'h1C, 2'h0}, '{8'h50, 8'h55, 8'h00, 2'h2}};
  fe_cfg_regs uut (.CLOCK, .ARST_N, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA,
    .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY,
    .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID,
    .S_AXI_RREADY, .ANALOG_CTRL);
  task automatic stop_test();
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r, input logic [3:0] st = 4'hF);
    @(posedge CLOCK);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= {24'h0, d};
    S_AXI_WSTRB <= st;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    // Address and data may be taken at different edges
    do
    begin
      @(posedge CLOCK);
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
    end
    while (S_AXI_AWVALID && !S_AXI_AWREADY || S_AXI_WVALID && !S_AXI_WREADY);
    do @(posedge CLOCK); while (!S_AXI_BVALID);
    r = S_AXI_BRESP;
    S_AXI_BREADY <= 1'b0;
  endtask : axi_wr
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input logic [1:0] s);
    @(posedge CLOCK);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    do @(posedge CLOCK); while (!S_AXI_ARREADY);
    S_AXI_ARVALID <= 1'b0;
    do @(posedge CLOCK); while (!S_AXI_RVALID);
    `CHK("rdata", {24'h0, e}, S_AXI_RDATA)
    `CHK("rresp", s, S_AXI_RRESP)
    S_AXI_RREADY <= 1'b0;
  endtask : rd_chk
  task automatic reset_check();
    rd_chk(8'h3C, 8'h00, 2'h0);
    rd_chk(8'h40, 8'h00, 2'h0);
    rd_chk(8'h44, 8'hFF, 2'h0);
    rd_chk(8'h48, 8'h00, 2'h0);
  endtask : reset_check
  initial
  begin
    CLOCK = 1'b0;
    forever #5 CLOCK = ~CLOCK;
  end
  always @(posedge CLOCK)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_count++;
      stop_test();
    end
  end
  initial
  begin
    logic [7:0] src_v, amp_v, bias_v;
    {ARST_N, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = '0;
    {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA, S_AXI_WSTRB} = '0;
    repeat (8) @(posedge CLOCK);
    ARST_N <= 1'b1;
    reset_check();
    foreach (rows[i])
    begin
      axi_wr(rows[i].a, rows[i].w, rs);
      `CHK("bresp", rows[i].s, rs)
      rd_chk(rows[i].a, rows[i].r, rows[i].s);
    end
    // Every selector and gain code; burnout stays within the defined codes
    for (int i = 0; i < 16; i++)
    begin
      src_v = {4'(i), 4'(15 - i)};
      amp_v = {i[3], 4'h0, i[2:0]};
      bias_v = {3'h0, i[1:0], 3'(i % 5)};
      axi_wr(8'h44, src_v, rs);
      axi_wr(8'h40, amp_v, rs);
      axi_wr(8'h48, bias_v, rs);
      rd_chk(8'h44, src_v, 2'h0);
      rd_chk(8'h40, amp_v, 2'h0);
      rd_chk(8'h48, bias_v, 2'h0);
      `CHK("pos", 16'h0001 << i, ANALOG_CTRL.pos_sel)
      `CHK("neg", 16'h0001 << (15 - i), ANALOG_CTRL.neg_sel)
      `CHK("gain", 8'h01 << i[2:0], ANALOG_CTRL.gain)
      `CHK("burnout", 5'h01 << (i % 5), ANALOG_CTRL.burnout)
      `CHK("bypass", i[3], ANALOG_CTRL.bypass)
      `CHK("bias_en", i[1], ANALOG_CTRL.bias_enable)
      `CHK("pull_dn", i[0], ANALOG_CTRL.pull_down)
      `CHK("bad", 1'b0, ANALOG_CTRL.burnout_bad)
    end
    // Write without the low byte strobe must leave the byte alone
    axi_wr(8'h40, 8'h00, rs, 4'hE);
    `CHK("bresp", 2'h0, rs)
    rd_chk(8'h40, 8'h87, 2'h0);
    `CHK("gain", 8'h80, ANALOG_CTRL.gain)
    // Reset in mid-run must restore every register
    ARST_N <= 1'b0;
    repeat (2) @(posedge CLOCK);
    ARST_N <= 1'b1;
    reset_check();
    stop_test();
  end
endmodule : testbench
`default_nettype wire
